/* hw/dmem_arb_map.vh */
`ifndef DMEM_ARB_MAP_VH
`define DMEM_ARB_MAP_VH

// Masters
`define M_CPU 2'd0
`define M_DRD 2'd1
`define M_DWR 2'd2
`define N_MASTERS 3

// Memory sections
`define SEC_IO 2'd0
`define SEC_EE 2'd1
`define SEC_SRAM 2'd2
`define N_SECTIONS 3

// Address bounds of the sections
`define EE_BASE 16'h1000
`define SRAM_BASE 16'h2000

// Access timing in cycles
`define IO_CYC 2'd1
`define SRAM_WR_CYC 2'd1
`define SRAM_RD_CYC 2'd2
`define SRAM_BURST_CYC 2'd1
`define EE_WR_CYC 2'd1
`define EE_RD_CYC 2'd3
`define EE_BURST_CYC 2'd2

// Lock groups
`define LK_CLK 2'd0
`define LK_EVT 2'd1
`define LK_WEX 2'd2

`endif

/* hw/section_arbiter.v */
`timescale 1ns/1ns
`default_nettype none
`include "dmem_arb_map.vh"

module section_arbiter (
    // Clock and reset
    input wire ref_clk,
    input wire rstn,
    // Requests from the three masters
    input wire [2:0] req,
    input wire [2:0] burst,
    input wire [2:0] wr,
    // Section kind, sets the beat timing
    input wire [1:0] sect,
    // Grant and beat strobe
    output reg [2:0] grant_q,
    output reg [2:0] done_q,
    output reg busy_q
);

// -----------------------------------------------------------------
// Beat length
// -----------------------------------------------------------------
function [1:0] beat_len;
    input [1:0] s;
    input b;
    input w;
    input first;
    begin
        if (s == `SEC_IO)
            beat_len = `IO_CYC;
        else if (s == `SEC_SRAM)
            beat_len = w ? `SRAM_WR_CYC :
                (b && !first) ? `SRAM_BURST_CYC : `SRAM_RD_CYC;
        else
            beat_len = w ? `EE_WR_CYC :
                (b && !first) ? `EE_BURST_CYC : `EE_RD_CYC;
    end
endfunction

reg [1:0] owner_q, owner_d;
reg bursting_q;
reg [1:0] cnt_q;
reg first_q;
reg dma_turn_q;
reg [2:0] pick;
reg pick_v;
reg last_beat;
reg [1:0] other;
reg [2:0] hold_off;
reg [2:0] req_m;

// -----------------------------------------------------------------
// Priority selection
// -----------------------------------------------------------------
always @* begin
    pick = 3'b000;
    pick_v = 1'b0;
    owner_d = owner_q;
    last_beat = busy_q && (cnt_q == 2'd1);
    other = (owner_q == `M_DRD) ? `M_DWR : `M_DRD;
    // A finished single access still shows its request until the
    // registered done reaches the master; keep it from a second grant
    hold_off = done_q & ~burst;
    if (last_beat && !burst[owner_q])
        hold_off[owner_q] = 1'b1;
    req_m = req & ~hold_off;
    if (busy_q && !last_beat) begin
        // Single access or burst beat in flight keeps the section
        pick_v = 1'b1;
    end else if (busy_q && bursting_q && req_m[owner_q] && burst[owner_q])
    begin
        // Two DMA bursts on one section take turns per beat
        if (owner_q != `M_CPU && req_m[other] && burst[other]) begin
            owner_d = other;
        end
        pick_v = 1'b1;
    end else if (|(req_m & burst)) begin
        pick_v = 1'b1;
        if (req_m[0] && burst[0])
            owner_d = `M_CPU;
        else if (req_m[1] && burst[1] && req_m[2] && burst[2])
            owner_d = dma_turn_q ? `M_DWR : `M_DRD;
        else if (req_m[1] && burst[1])
            owner_d = `M_DRD;
        else
            owner_d = `M_DWR;
    end else if (|req_m) begin
        pick_v = 1'b1;
        if (req_m[0])
            owner_d = `M_CPU;
        else if (req_m[1])
            owner_d = `M_DRD;
        else
            owner_d = `M_DWR;
    end
    if (pick_v)
        pick[owner_d] = 1'b1;
end

// -----------------------------------------------------------------
// Grant state, evaluated every cycle
// -----------------------------------------------------------------
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        owner_q <= 2'd0;
        grant_q <= 3'b000;
        done_q <= 3'b000;
        busy_q <= 1'b0;
        bursting_q <= 1'b0;
        cnt_q <= 2'd0;
        first_q <= 1'b0;
        dma_turn_q <= 1'b0;
    end else begin
        grant_q <= pick;
        done_q <= 3'b000;
        if (last_beat)
            done_q[owner_q] <= 1'b1;
        if (busy_q && !last_beat) begin
            cnt_q <= cnt_q - 2'd1;
        end else if (pick_v) begin
            // Continuing the same burst skips the first-word latency
            first_q <= !(busy_q && bursting_q && owner_d == owner_q);
            cnt_q <= beat_len(sect, burst[owner_d], wr[owner_d],
                !(busy_q && bursting_q && owner_d == owner_q));
            owner_q <= owner_d;
            bursting_q <= burst[owner_d];
            busy_q <= 1'b1;
            if (owner_d != `M_CPU)
                dma_turn_q <= (owner_d == `M_DRD);
        end else begin
            busy_q <= 1'b0;
            bursting_q <= 1'b0;
        end
    end
end

endmodule
`default_nettype wire

/* hw/data_memory_bus_arbiter.v */
// How it works
// - Three memory sections each have their own arbiter and grant.
// - An in-flight single access keeps its section until finished.
// - An ongoing burst ranks second, above every new request.
// - Two DMA bursts to one section alternate grants each beat.
// - New bursts rank third; the processor core wins ties.
// - New single accesses rank last; the processor core wins ties.
// - I/O memory reads and writes finish in one cycle.
// - SRAM write takes one cycle, single SRAM read two cycles.
// - SRAM burst read gives a word every cycle after the first.
// - EEPROM buffer load one cycle, single EEPROM read three cycles.
// - EEPROM burst read gives a word every second cycle.
// - Writes to registers under a set lock are ignored.
// - Lock registers are written only when the guard authorises.
`timescale 1ns/1ns
`default_nettype none
`include "dmem_arb_map.vh"

module data_memory_bus_arbiter (
    // Clock and reset
    input wire ref_clk,
    input wire rstn,
    // Processor core request
    input wire cpu_req,
    input wire cpu_burst,
    input wire cpu_wr,
    input wire [15:0] cpu_addr,
    // DMA controller read side
    input wire drd_req,
    input wire drd_burst,
    input wire [15:0] drd_addr,
    // DMA controller write side
    input wire dwr_req,
    input wire dwr_burst,
    input wire [15:0] dwr_addr,
    // Grants, one per master per section (bit = master)
    output reg [2:0] io_grant_q,
    output reg [2:0] ee_grant_q,
    output reg [2:0] sram_grant_q,
    // Beat done strobes per master
    output reg [2:0] done_q,
    // Lockable register write gate
    input wire lk_wr,
    input wire [1:0] lk_group,
    input wire lock_reg_wr,
    input wire [2:0] lock_wdata,
    input wire config_change_guard,
    output reg [2:0] lock_q,
    output reg lk_wr_en_q
);

// -----------------------------------------------------------------
// Section decode
// -----------------------------------------------------------------
function [1:0] sect_of;
    input [15:0] a;
    begin
        if (a >= `SRAM_BASE)
            sect_of = `SEC_SRAM;
        else if (a >= `EE_BASE)
            sect_of = `SEC_EE;
        else
            sect_of = `SEC_IO;
    end
endfunction

wire [1:0] cpu_s = sect_of(cpu_addr);
wire [1:0] drd_s = sect_of(drd_addr);
wire [1:0] dwr_s = sect_of(dwr_addr);
wire [2:0] req_v = {dwr_req, drd_req, cpu_req};
wire [2:0] bst_v = {dwr_burst, drd_burst, cpu_burst};
wire [2:0] wr_v = {1'b1, 1'b0, cpu_wr};
wire [8:0] g_w;
wire [8:0] d_w;
wire [2:0] b_w;

// -----------------------------------------------------------------
// One arbiter per section
// -----------------------------------------------------------------
genvar s;
generate
    for (s = 0; s < `N_SECTIONS; s = s + 1) begin : g_sec
        localparam [1:0] SK = s;
        wire [2:0] r = req_v & {dwr_s == s, drd_s == s, cpu_s == s};
        section_arbiter u_arb (
            .ref_clk(ref_clk),
            .rstn(rstn),
            .req(r),
            .burst(bst_v),
            .wr(wr_v),
            .sect(SK),
            .grant_q(g_w[3*s+2:3*s]),
            .done_q(d_w[3*s+2:3*s]),
            .busy_q(b_w[s])
        );
    end
endgenerate

// -----------------------------------------------------------------
// Output registers
// -----------------------------------------------------------------
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        io_grant_q <= 3'b000;
        ee_grant_q <= 3'b000;
        sram_grant_q <= 3'b000;
        done_q <= 3'b000;
    end else begin
        // Registered copy adds one cycle to grants and strobes
        io_grant_q <= g_w[2:0];
        ee_grant_q <= g_w[5:3];
        sram_grant_q <= g_w[8:6];
        done_q <= d_w[2:0] | d_w[5:3] | d_w[8:6];
    end
end

// -----------------------------------------------------------------
// I/O lock protection
// -----------------------------------------------------------------
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        lock_q <= 3'b000;
        lk_wr_en_q <= 1'b0;
    end else begin
        if (lock_reg_wr && config_change_guard)
            lock_q <= lock_wdata;
        // Group code 3 has no lock bit and is never blocked
        lk_wr_en_q <= lk_wr && !(lk_group != 2'd3 && lock_q[lk_group]);
    end
end

endmodule
`default_nettype wire

/* test/data_memory_bus_arbiter_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module dmem_arb_chk (
    // Inputs of the arbiter
    input wire logic ref_clk, rstn, cpu_req, cpu_burst, cpu_wr,
    input wire logic drd_req, drd_burst, dwr_req, dwr_burst,
    input wire logic [15:0] cpu_addr, drd_addr, dwr_addr,
    input wire logic lk_wr, lock_reg_wr, config_change_guard,
    input wire logic [1:0] lk_group,
    input wire logic [2:0] lock_wdata,
    // Outputs of the arbiter
    input wire logic [2:0] io_grant_q, ee_grant_q, sram_grant_q,
    input wire logic [2:0] done_q, lock_q,
    input wire logic lk_wr_en_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_rd2(d);
        !d ##1 d;
    endsequence
    sequence s_rd3(d);
        !d [*2] ##1 d;
    endsequence
    a_io_onehot: assert property ($onehot0(io_grant_q))
        else $error("io grant not one-hot");
    a_ee_onehot: assert property ($onehot0(ee_grant_q))
        else $error("ee grant not one-hot");
    a_sram_onehot: assert property ($onehot0(sram_grant_q))
        else $error("sram grant not one-hot");
    a_io_beat: assert property ($rose(io_grant_q[0]) |=> done_q[0])
        else $error("io access not one cycle");
    a_sram_read: assert property ($rose(sram_grant_q[0]) && !cpu_burst
        && !cpu_wr |=> s_rd2(done_q[0])) else $error("sram read timing");
    a_sram_write: assert property ($rose(sram_grant_q[2])
        && !dwr_burst |=> done_q[2]) else $error("sram write timing");
    a_ee_read: assert property ($rose(ee_grant_q[1]) && !drd_burst
        |=> s_rd3(done_q[1])) else $error("ee read timing");
    a_lock_block: assert property (lk_wr && lk_group != 2'h3
        && lock_q[lk_group] |=> !lk_wr_en_q) else $error("locked write");
    a_lock_keep: assert property (!(lock_reg_wr && config_change_guard)
        |=> $stable(lock_q)) else $error("lock changed unguarded");
    a_lock_load: assert property (lock_reg_wr && config_change_guard
        |=> (lock_q & $past(lock_wdata)) == $past(lock_wdata))
        else $error("guarded lock write lost");
endmodule
bind data_memory_bus_arbiter dmem_arb_chk dmem_arb_chk_inst (.*);
`default_nettype wire

/* test/bus_master.sv */
`timescale 1ns/1ns
`default_nettype none
module bus_master (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic [3:0] beats,
    input wire logic done,
    output logic req
);
    logic [3:0] left;
    // Request held until its last beat is done
    always @(negedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            req <= 1'b0;
            left <= 4'h0;
        end else if (!req && start) begin
            req <= 1'b1;
            left <= beats;
        end else if (req && done) begin
            left <= left - 4'h1;
            if (left == 4'h1) req <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* test/data_memory_bus_arbiter_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module data_memory_bus_arbiter_tb;
    logic ref_clk = 0, rstn = 0, cpu_burst = 0, cpu_wr = 0;
    logic drd_burst = 0, dwr_burst = 0, lk_wr = 0, lock_reg_wr = 0;
    logic config_change_guard = 0;
    logic [15:0] cpu_addr = 16'h0, drd_addr = 16'h0, dwr_addr = 16'h0;
    logic [1:0] lk_group = 2'h0, prv;
    logic [2:0] lock_wdata = 3'h0, st = 3'h0;
    logic [11:0] nb = 12'h111;
    wire cpu_req, drd_req, dwr_req;
    logic [2:0] io_grant_q, ee_grant_q, sram_grant_q, done_q, lock_q;
    logic lk_wr_en_q;
    int failures = 0, checks_done = 0;
    data_memory_bus_arbiter data_memory_bus_arbiter_inst (.*);
    bus_master m0 (.ref_clk, .rstn, .start(st[0]), .beats(nb[3:0]),
        .done(done_q[0]), .req(cpu_req));
    bus_master m1 (.ref_clk, .rstn, .start(st[1]), .beats(nb[7:4]),
        .done(done_q[1]), .req(drd_req));
    bus_master m2 (.ref_clk, .rstn, .start(st[2]), .beats(nb[11:8]),
        .done(done_q[2]), .req(dwr_req));
    initial forever #5 ref_clk = ~ref_clk;
    task chk(input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask
    task wrap_up;
        if (failures == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task go(input logic [2:0] m);
        @(negedge ref_clk) st <= m;
        @(negedge ref_clk) st <= 3'h0;
    endtask
    task wait_g(input logic [8:0] mask);
        int i;
        for (i = 0; i < 60 && !(|({sram_grant_q, ee_grant_q, io_grant_q}
            & mask)); i++) @(negedge ref_clk);
        if (i == 60) begin
            failures++;
            wrap_up;
        end
    endtask
    task io_pair;
        cpu_addr = 16'h0010;
        drd_addr = 16'h0020;
        go(3'h3);
        wait_g(9'h007);
        chk(io_grant_q, 3'h1);
        wait_g(9'h002);
        chk(io_grant_q, 3'h2);
        repeat (4) @(negedge ref_clk);
    endtask
    task three_sect;
        cpu_addr = 16'h0040;
        drd_addr = 16'h1000;
        dwr_addr = 16'h2000;
        go(3'h7);
        wait_g(9'h007);
        chk({sram_grant_q, ee_grant_q, io_grant_q}, 9'h111);
        repeat (8) @(negedge ref_clk);
    endtask
    task burst_first;
        int n;
        cpu_addr = 16'h2010;
        drd_addr = 16'h2100;
        drd_burst = 1;
        nb = 12'h131;
        go(3'h3);
        wait_g(9'h1C0);
        chk(sram_grant_q, 3'h2);
        for (n = 0; n < 60 && drd_req; n++) begin
            chk(sram_grant_q[0], 1'b0);
            @(negedge ref_clk);
        end
        if (n == 60) begin
            failures++;
            wrap_up;
        end
        wait_g(9'h040);
        repeat (6) @(negedge ref_clk);
    endtask
    task dma_alt;
        dwr_addr = 16'h2200;
        dwr_burst = 1;
        nb = 12'h441;
        prv = 2'h0;
        go(3'h6);
        repeat (60) begin
            @(negedge ref_clk);
            if (done_q[2:1] != 2'h0) begin
                if (prv != 2'h0 && drd_req && dwr_req)
                    chk(done_q[2:1], ~prv & 2'h3);
                prv = done_q[2:1];
            end
        end
    endtask
    task burst_gap(input logic [15:0] addr, input logic [8:0] exp);
        int n, gap, seen;
        drd_addr = addr;
        drd_burst = 1;
        nb = 12'h131;
        gap = 0;
        seen = 0;
        go(3'h2);
        for (n = 0; n < 40 && seen < 3; n++) begin
            @(negedge ref_clk);
            gap++;
            if (done_q[1]) begin
                if (seen > 0) chk(gap[8:0], exp);
                seen++;
                gap = 0;
            end
        end
        if (seen < 3) failures++;
        repeat (8) @(negedge ref_clk);
    endtask
    task ee_write;
        cpu_addr = 16'h1010;
        cpu_wr = 1;
        nb = 12'h111;
        go(3'h1);
        wait_g(9'h008);
        @(negedge ref_clk);
        chk(done_q[0], 1'b1);
        cpu_wr = 0;
        repeat (6) @(negedge ref_clk);
    endtask
    task locks;
        lock_wdata = 3'h1;
        lock_reg_wr = 1;
        @(negedge ref_clk) lock_reg_wr = 0;
        chk(lock_q, 3'h0);
        config_change_guard = 1;
        lock_reg_wr = 1;
        @(negedge ref_clk) lock_reg_wr = 0;
        config_change_guard = 0;
        chk(lock_q, 3'h1);
        lk_wr = 1;
        @(negedge ref_clk) lk_group = 2'h1;
        chk(lk_wr_en_q, 1'b0);
        @(negedge ref_clk) lk_wr = 0;
        chk(lk_wr_en_q, 1'b1);
    endtask
    initial begin
        repeat (10) @(negedge ref_clk);
        rstn = 1;
        io_pair;
        three_sect;
        burst_first;
        dma_alt;
        burst_gap(16'h2100, 9'h001);
        burst_gap(16'h1100, 9'h002);
        ee_write;
        locks;
        wrap_up;
    end
endmodule
`default_nettype wire
